//--- include/timer16_pkg.sv
// constants shared by the 16-bit timer/counter and its helpers
package timer16_pkg;
    // register byte offsets on the bus
    localparam int             ADDR_W        = 8;
    localparam logic [7:0]     OFF_CTRL      = 8'h00;
    localparam logic [7:0]     OFF_LOW       = 8'h04;
    localparam logic [7:0]     OFF_HIGH      = 8'h08;
    localparam logic [7:0]     OFF_IRQ_REQ   = 8'h0C;
    localparam logic [7:0]     OFF_IRQ_EN    = 8'h10;
    localparam logic [7:0]     OFF_CMP_MODE  = 8'h14;
    // timer_control field positions
    localparam int             BIT_RUN       = 0;
    localparam int             BIT_SRC       = 1;
    localparam int             BIT_SYNC_DIS  = 2;
    localparam int             BIT_OSC_EN    = 3;
    localparam int             BIT_PS_LO     = 4;
    localparam int             BIT_PS_HI     = 5;
    localparam int             BIT_UNUSED    = 6;
    localparam int             BIT_WIDE      = 7;
    localparam logic [7:0]     CTRL_WMASK    = 8'hBF;
    localparam logic [7:0]     CTRL_RESET    = 8'h00;
    // interrupt request / enable bit position
    localparam int             BIT_OVF       = 0;
    // compare unit mode that fires the special event trigger
    localparam logic [3:0]     CMP_SPECIAL   = 4'hB;
    localparam logic [3:0]     CMP_RESET     = 4'h0;
    // counter values
    localparam logic [15:0]    COUNT_RESET   = 16'h0000;
    localparam logic [15:0]    COUNT_MAX     = 16'hFFFF;
    localparam logic [7:0]     BYTE_RESET    = 8'h00;
    // clock and instruction cycle
    localparam int             CLK_HZ        = 10_000_000;
    localparam int             CLK_PERIOD_NS = 100;
    localparam int             INSTR_DIV     = 4;
    localparam int             PS_W          = 3;
endpackage

//--- src/edge_sync.sv
// three-stage pin synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // s1 feeds s2 only; metastability must settle before use
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= raw_in[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    level_out[i] <= 1'b0;
                    rise_out[i]  <= 1'b0;
                end else begin
                    if (s2 == s3) begin
                        level_out[i] <= s3;
                    end
                    rise_out[i] <= (s2 == s3) && s3 && !level_out[i];
                end
            end
        end
    endgenerate
endmodule // edge_sync
`default_nettype wire

//--- src/prescale_div.sv
// 1:1 / 1:2 / 1:4 / 1:8 input prescaler
`timescale 1ns/1ps
`default_nettype none
module prescale_div #(
    parameter int W = timer16_pkg::PS_W
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       tick_in,
    input  wire logic       clear_in,
    input  wire logic [1:0] sel_in,
    output logic            tick_out
);
    logic [W-1:0] count;
    logic [W-1:0] mask;

    always_comb begin
        case (sel_in)
            2'h0:    mask = W'(0);
            2'h1:    mask = W'(1);
            2'h2:    mask = W'(3);
            default: mask = W'(7);
        endcase
    end

    assign tick_out = tick_in && ((count & mask) == mask);

    // clear wins over a tick in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || clear_in) begin
            count <= '0;
        end else if (tick_in) begin
            count <= W'(count + W'(1));
        end
    end
endmodule // prescale_div
`default_nettype wire

//--- src/timer16_top.sv
// 16-bit timer/counter with crystal source, prescaler and apb registers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module timer16_top (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        ext_count_clock_pin_in,
    input  wire logic        crystal_in_pin_in,
    input  wire logic        osc_clock_in,
    input  wire logic [1:0]  port_direction_in,
    output logic             crystal_osc_enable_out,
    output logic      [1:0]  pin_oe_out,
    output logic      [1:0]  pin_read_out,
    input  wire logic        sleep_in,
    input  wire logic        trigger_in,
    input  wire logic        adc_enable_in,
    output logic             adc_start_out,
    output logic             overflow_irq_out
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  timer_control;
    logic [15:0] count;
    logic [7:0]  high_buffer;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic [3:0]  compare_mode_code;
    logic [1:0]  instr_phase;

    logic        run_enable;
    logic        clock_source_select;
    logic        ext_sync_disable;
    logic        crystal_osc_enable;
    logic        wide_access_enable;
    logic [1:0]  prescale_select;

    assign run_enable          = timer_control[timer16_pkg::BIT_RUN];
    assign clock_source_select = timer_control[timer16_pkg::BIT_SRC];
    assign ext_sync_disable    = timer_control[timer16_pkg::BIT_SYNC_DIS];
    assign crystal_osc_enable  = timer_control[timer16_pkg::BIT_OSC_EN];
    assign wide_access_enable  = timer_control[timer16_pkg::BIT_WIDE];
    assign prescale_select     = timer_control[timer16_pkg::BIT_PS_HI:
                                               timer16_pkg::BIT_PS_LO];

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic setup_cyc;
    logic access_cyc;
    logic wr_lane0;
    logic rd_setup;
    logic mapped;
    logic wr_ctrl;
    logic wr_low;
    logic wr_high;
    logic wr_req;
    logic wr_en;
    logic wr_cmp;

    assign setup_cyc  = psel_in && !penable_in;
    assign access_cyc = psel_in && penable_in;
    assign wr_lane0   = access_cyc && pwrite_in && pstrb_in[0];
    assign rd_setup   = setup_cyc && !pwrite_in;
    assign mapped     = (paddr_in == timer16_pkg::OFF_CTRL)
                     || (paddr_in == timer16_pkg::OFF_LOW)
                     || (paddr_in == timer16_pkg::OFF_HIGH)
                     || (paddr_in == timer16_pkg::OFF_IRQ_REQ)
                     || (paddr_in == timer16_pkg::OFF_IRQ_EN)
                     || (paddr_in == timer16_pkg::OFF_CMP_MODE);
    assign wr_ctrl = wr_lane0 && (paddr_in == timer16_pkg::OFF_CTRL);
    assign wr_low  = wr_lane0 && (paddr_in == timer16_pkg::OFF_LOW);
    assign wr_high = wr_lane0 && (paddr_in == timer16_pkg::OFF_HIGH);
    assign wr_req  = wr_lane0 && (paddr_in == timer16_pkg::OFF_IRQ_REQ);
    assign wr_en   = wr_lane0 && (paddr_in == timer16_pkg::OFF_IRQ_EN);
    assign wr_cmp  = wr_lane0 && (paddr_in == timer16_pkg::OFF_CMP_MODE);

    // read data is latched in setup, so every access takes two cycles
    assign pready_out  = access_cyc;
    assign pslverr_out = access_cyc && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // count sources
    logic [0:0] src_rise;
    logic [1:0] pin_level;
    logic       raw_source;
    logic       instr_tick;
    logic       source_tick;
    logic       pre_in;
    logic       pre_tick;
    logic       sync_mode;
    logic       async_mode;
    logic       sync_tog;
    logic       sync_a;
    logic       sync_b;
    logic       sync_c;
    logic       advance;
    logic       special_trig;

    // oscillator output replaces the pin as external source when enabled
    assign raw_source = crystal_osc_enable ? osc_clock_in
                                           : ext_count_clock_pin_in;

    edge_sync #(.WIDTH(1)) u_src_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .raw_in     (raw_source),
        .level_out  (),
        .rise_out   (src_rise)
    );

    edge_sync #(.WIDTH(2)) u_pin_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .raw_in     ({crystal_in_pin_in, ext_count_clock_pin_in}),
        .level_out  (pin_level),
        .rise_out   ()
    );

    // instruction cycle is one clock in four; it stops during sleep
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            instr_phase <= 2'h0;
        end else begin
            instr_phase <= 2'(instr_phase + 2'h1);
        end
    end
    assign instr_tick = (instr_phase == 2'(timer16_pkg::INSTR_DIV - 1))
                     && !sleep_in;

    assign sync_mode  = clock_source_select && !ext_sync_disable;
    assign async_mode = clock_source_select && ext_sync_disable;

    // only the asynchronous path keeps running while asleep
    always_comb begin
        if (!clock_source_select) begin
            source_tick = instr_tick;
        end else if (async_mode) begin
            source_tick = src_rise[0];
        end else begin
            source_tick = src_rise[0] && !sleep_in;
        end
    end
    assign pre_in = run_enable && source_tick;

    prescale_div #(.W(timer16_pkg::PS_W)) u_prescale (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .tick_in    (pre_in),
        .clear_in   (wr_low),
        .sel_in     (prescale_select),
        .tick_out   (pre_tick)
    );

    // prescaled event carried as a toggle through three more stages
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_tog <= 1'b0;
            sync_a   <= 1'b0;
            sync_b   <= 1'b0;
            sync_c   <= 1'b0;
        end else begin
            sync_tog <= sync_tog ^ pre_tick;
            sync_a   <= sync_tog;
            sync_b   <= sync_a;
            sync_c   <= sync_b;
        end
    end

    always_comb begin
        if (sync_mode) begin
            advance = run_enable && (sync_b ^ sync_c);
        end else begin
            advance = run_enable && pre_tick;
        end
    end

    assign special_trig = trigger_in
                       && (compare_mode_code == timer16_pkg::CMP_SPECIAL);
    assign adc_start_out = special_trig && adc_enable_in;

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            timer_control <= timer16_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            timer_control <= pwdata_in[7:0]
                           & timer16_pkg::CTRL_WMASK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            overflow_irq_enable <= 1'b0;
            compare_mode_code   <= timer16_pkg::CMP_RESET;
        end else begin
            if (wr_en) begin
                overflow_irq_enable <= pwdata_in[timer16_pkg::BIT_OVF];
            end
            if (wr_cmp) begin
                compare_mode_code <= pwdata_in[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter
    logic wrap;
    assign wrap = advance && (count == timer16_pkg::COUNT_MAX)
               && !wr_low && !wr_high && !special_trig;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count <= timer16_pkg::COUNT_RESET;
        end else if (wr_low && wide_access_enable) begin
            count <= {high_buffer, pwdata_in[7:0]};
        end else if (wr_low) begin
            count[7:0] <= pwdata_in[7:0];
        end else if (wr_high && !wide_access_enable) begin
            count[15:8] <= pwdata_in[7:0];
        end else if (special_trig && !wr_high) begin
            count <= timer16_pkg::COUNT_RESET;
        end else if (advance && !wr_high) begin
            count <= 16'(count + 16'h0001);
        end
    end

    // a wide-mode high write buffers only; the counter holds for that cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            high_buffer <= timer16_pkg::BYTE_RESET;
        end else if (wr_high && wide_access_enable) begin
            high_buffer <= pwdata_in[7:0];
        end else if (rd_setup && wide_access_enable
                     && paddr_in == timer16_pkg::OFF_LOW) begin
            high_buffer <= count[15:8];
        end
    end

    // the set wins over a clear; the trigger path never reaches it
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr_req) begin
            overflow_flag <= pwdata_in[timer16_pkg::BIT_OVF];
        end
    end

    assign overflow_irq_out = overflow_flag && overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // pins
    assign crystal_osc_enable_out = crystal_osc_enable;
    // direction bit high means input, as for a port direction latch
    assign pin_oe_out   = crystal_osc_enable ? 2'h0
                                             : ~port_direction_in;
    assign pin_read_out = crystal_osc_enable ? 2'h0 : pin_level;

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr_in)
                timer16_pkg::OFF_CTRL:
                    prdata_out <= {24'h000000, timer_control};
                timer16_pkg::OFF_LOW:
                    prdata_out <= {24'h000000, count[7:0]};
                timer16_pkg::OFF_HIGH:
                    prdata_out <= {24'h000000, wide_access_enable
                                   ? high_buffer : count[15:8]};
                timer16_pkg::OFF_IRQ_REQ:
                    prdata_out <= {31'h00000000, overflow_flag};
                timer16_pkg::OFF_IRQ_EN:
                    prdata_out <= {31'h00000000, overflow_irq_enable};
                timer16_pkg::OFF_CMP_MODE:
                    prdata_out <= {28'h0000000, compare_mode_code};
                default:
                    prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    logic quiet;
    assign quiet = !wr_low && !wr_high && !special_trig;

    sequence s_stopped;
        !run_enable && quiet;
    endsequence
    sequence s_sync_event;
        sync_mode && run_enable && pre_tick ##1
        (sync_mode && run_enable) [*3];
    endsequence

    a_stop_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_stopped |=> count == $past(count))
        else $error("count moved while stopped");
    a_ctrl_bit6: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_ctrl |=> !timer_control[timer16_pkg::BIT_UNUSED])
        else $error("unimplemented control bit set");
    a_wrap_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wrap |=> count == timer16_pkg::COUNT_RESET && overflow_flag)
        else $error("wrap did not clear count and set flag");
    a_flag_cause: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $rose(overflow_flag) |-> $past(wrap) || $past(wr_req))
        else $error("overflow flag set without wrap");
    a_trig_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        special_trig && !wr_low && !wr_high
        |=> count == timer16_pkg::COUNT_RESET)
        else $error("trigger did not clear count");
    a_write_wins: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_low && wide_access_enable && special_trig
        |=> count == {$past(high_buffer), $past(pwdata_in[7:0])})
        else $error("trigger beat software write");
    a_wide_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        wr_high && wide_access_enable && !advance
        |=> count == $past(count) && high_buffer == $past(pwdata_in[7:0]))
        else $error("wide high write touched counter");
    a_read_snap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        rd_setup && wide_access_enable && !wr_high
        && paddr_in == timer16_pkg::OFF_LOW
        |=> high_buffer == $past(count[15:8]))
        else $error("low read did not snapshot high byte");
    a_sync_delay: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_sync_event |-> advance)
        else $error("synchronised advance missing");
    a_pins_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        crystal_osc_enable |-> pin_oe_out == 2'h0 && pin_read_out == 2'h0)
        else $error("pins not forced to input");
endmodule // timer16_top
`default_nettype wire

//--- tb/event_source_model.sv
// far-side model: count pulse train on the pins and compare trigger pulse
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
    input  wire logic       clk_in,
    input  wire logic       fire_in,
    input  wire logic       start_in,
    input  wire logic [3:0] pulses_in,
    output logic            pin_out,
    output logic            trigger_out,
    output logic            busy_out
);
    logic [3:0] left = 4'h0;
    logic [4:0] ph   = 5'h00;
    logic       trig = 1'b0;
    ////////////////////////////////////////
    always @(posedge clk_in) begin
        trig <= fire_in;
        if (start_in) begin
            left <= pulses_in;
            ph <= 5'h00;
        end else if (left != 4'h0) begin
            ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
            if (ph == 5'h13) begin
                left <= left - 4'h1;
            end
        end
    end
    // ten clocks high, ten low: wide enough for the pin filter
    assign pin_out     = (left != 4'h0) && (ph < 5'h0A);
    assign busy_out    = (left != 4'h0);
    assign trigger_out = trig;
endmodule // event_source_model
`default_nettype wire

//--- tb/sixteen_bit_timer_with_rtc_osc_bench.sv
// self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_with_rtc_osc_bench;
    typedef struct packed {logic [7:0] a, d, e; logic se;} row_t;
    logic        clk_in     = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  paddr_in   = 8'h00;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [31:0] pwdata_in  = 32'h0;
    logic [1:0]  dir        = 2'b01;
    logic        sleep      = 1'b0;
    logic        adc_en     = 1'b0;
    logic        fire       = 1'b0;
    logic        start      = 1'b0;
    logic [31:0] prdata_out;
    logic [1:0]  oe, pin_rd, pin_seen;
    logic        pready_out, pslverr_out, osc_en, adc_go, irq;
    logic        pin, trig, busy, err;
    logic [7:0]  rd, cfg;
    int          miscompares = 0;
    int          checks_done = 0;
    row_t        rows [7] = '{'{timer16_pkg::OFF_CTRL, 8'hFF, 8'hBF, 1'b0},
        '{timer16_pkg::OFF_CTRL, 8'h00, 8'h00, 1'b0},
        '{timer16_pkg::OFF_IRQ_EN, 8'hFF, 8'h01, 1'b0},
        '{timer16_pkg::OFF_CMP_MODE, 8'h0B, 8'h0B, 1'b0},
        '{timer16_pkg::OFF_HIGH, 8'h5A, 8'h5A, 1'b0},
        '{timer16_pkg::OFF_LOW, 8'hA5, 8'hA5, 1'b0},
        '{8'h20, 8'h77, 8'h00, 1'b1}};
    ////////////////////////////////////////
    timer16_top i_timer16_top (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .paddr_in(paddr_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .pwdata_in(pwdata_in), .pstrb_in(4'hF), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .ext_count_clock_pin_in(pin), .crystal_in_pin_in(pin),
        .osc_clock_in(pin), .port_direction_in(dir),
        .crystal_osc_enable_out(osc_en), .pin_oe_out(oe),
        .pin_read_out(pin_rd), .sleep_in(sleep), .trigger_in(trig),
        .adc_enable_in(adc_en), .adc_start_out(adc_go),
        .overflow_irq_out(irq));
    event_source_model i_event_source_model (
        .clk_in(clk_in), .fire_in(fire), .start_in(start),
        .pulses_in(4'h5), .pin_out(pin), .trigger_out(trig),
        .busy_out(busy));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    ////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input logic [7:0] lo, hi, g);
        checks_done++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("unexpected %s expected %h..%h seen %h", n, lo, hi, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= {24'h0, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            test_done();
        end
        rd = prdata_out[7:0];
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, e);
        apb(1'b0, a, 8'h00);
        chk(n, e, rd);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rdc("control reset", timer16_pkg::OFF_CTRL, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 8'h00);
            chk("row data", rows[i].e, rd);
            chk("row error", {7'h0, rows[i].se}, {7'h0, err});
        end
        for (int p = 0; p < 4; p++) begin
            cfg = 8'(p << 4);
            wr(timer16_pkg::OFF_CTRL, cfg);
            wr(timer16_pkg::OFF_HIGH, 8'h00);
            wr(timer16_pkg::OFF_LOW, 8'h00);
            wr(timer16_pkg::OFF_CTRL, cfg | 8'h01);
            repeat (80 << p) @(posedge clk_in);
            wr(timer16_pkg::OFF_CTRL, cfg);
            apb(1'b0, timer16_pkg::OFF_LOW, 8'h00);
            chk_rng("prescaled count", 8'h13, 8'h15, rd);
            repeat (40) @(posedge clk_in);
            rdc("held count", timer16_pkg::OFF_LOW, rd);
        end
        wr(timer16_pkg::OFF_IRQ_REQ, 8'h00);
        wr(timer16_pkg::OFF_HIGH, 8'hFF);
        wr(timer16_pkg::OFF_LOW, 8'hFE);
        wr(timer16_pkg::OFF_CTRL, 8'h01);
        repeat (40) @(posedge clk_in);
        wr(timer16_pkg::OFF_CTRL, 8'h00);
        rdc("wrapped high", timer16_pkg::OFF_HIGH, 8'h00);
        rdc("overflow flag", timer16_pkg::OFF_IRQ_REQ, 8'h01);
        chk("irq enabled", 8'h01, {7'h0, irq});
        wr(timer16_pkg::OFF_IRQ_EN, 8'h00);
        @(posedge clk_in);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(timer16_pkg::OFF_IRQ_REQ, 8'h00);
        adc_en <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(timer16_pkg::OFF_HIGH, 8'h12);
            wr(timer16_pkg::OFF_LOW, 8'h34);
            fire <= 1'b1; // special event clears count and starts the adc on the first pass only
            @(posedge clk_in);
            fire <= 1'b0;
            @(posedge clk_in);
            chk("adc start", {7'h0, m == 0}, {7'h0, adc_go});
            rdc("after trigger", timer16_pkg::OFF_HIGH,
                m == 0 ? 8'h00 : 8'h12);
            wr(timer16_pkg::OFF_CMP_MODE, timer16_pkg::CMP_SPECIAL ^ 8'h0B);
        end
        rdc("flag after trigger", timer16_pkg::OFF_IRQ_REQ, 8'h00);
        wr(timer16_pkg::OFF_CMP_MODE, {4'h0, timer16_pkg::CMP_SPECIAL});
        wr(timer16_pkg::OFF_HIGH, 8'h56);
        fork
            wr(timer16_pkg::OFF_LOW, 8'h78);
            begin
                @(posedge clk_in);
                fire <= 1'b1;
                @(posedge clk_in);
                fire <= 1'b0;
            end
        join
        rdc("write wins", timer16_pkg::OFF_LOW, 8'h78);
        wr(timer16_pkg::OFF_CTRL, 8'h80);
        wr(timer16_pkg::OFF_HIGH, 8'hAB);
        wr(timer16_pkg::OFF_LOW, 8'hCD);
        wr(timer16_pkg::OFF_HIGH, 8'h11);
        wr(timer16_pkg::OFF_CTRL, 8'h00);
        rdc("wide high", timer16_pkg::OFF_HIGH, 8'hAB);
        rdc("wide low", timer16_pkg::OFF_LOW, 8'hCD);
        wr(timer16_pkg::OFF_CTRL, 8'h80);
        rdc("buffer", timer16_pkg::OFF_HIGH, 8'h11);
        rdc("wide low read", timer16_pkg::OFF_LOW, 8'hCD);
        rdc("snapshot", timer16_pkg::OFF_HIGH, 8'hAB);
        for (int k = 0; k < 3; k++) begin
            cfg = k == 0 ? 8'h02 : (k == 1 ? 8'h06 : 8'h0E);
            sleep <= k != 0;
            wr(timer16_pkg::OFF_CTRL, cfg);
            repeat (20) @(posedge clk_in); // oscillator start-up
            wr(timer16_pkg::OFF_HIGH, 8'h00);
            wr(timer16_pkg::OFF_LOW, 8'h00);
            wr(timer16_pkg::OFF_CTRL, cfg | 8'h01);
            start <= 1'b1;
            pin_seen = 2'h0;
            @(posedge clk_in);
            start <= 1'b0;
            @(posedge clk_in);
            for (int n = 0; busy !== 1'b0; n++) begin
                @(posedge clk_in);
                pin_seen = pin_seen | pin_rd;
                if (k == 2)
                    chk("pin read", 8'h00, {6'h0, pin_rd});
                if (n > 500) begin
                    miscompares++;
                    test_done();
                end
            end
            repeat (20) @(posedge clk_in);
            chk("pin enable", k == 2 ? 8'h00 : 8'h02, {6'h0, oe});
            chk("pin seen", k == 2 ? 8'h00 : 8'h03, {6'h0, pin_seen});
            chk("osc enable", {7'h0, k == 2}, {7'h0, osc_en});
            wr(timer16_pkg::OFF_CTRL, cfg);
            rdc("edge count", timer16_pkg::OFF_LOW,
                8'h05);
        end
        test_done();
    end
endmodule // sixteen_bit_timer_with_rtc_osc_bench
`default_nettype wire
